//--- hdl/hsc_homing_stop.sv
// Homing, jog, positioning and stop sequencer with Avalon-MM register slave
// Functional notes
// (R1) Origin-seek assertion starts homing in the configured return direction.
// (R2) After homing, move by home offset; that point becomes the reference.
// (R3) Position at the reference is cleared to zero when homing completes.
// (R4) Homing supports two-sensor constant speed and three-sensor high speed.
// (R5) Homing path depends on start direction and current sensor region.
// (R6) Two-sensor and push mode homing run rectangular at starting speed.
// (R7) Software keeps push-mode homing start speed at or below 6.0 mm/s.
// (R8) Manual jog low speed while key held; shift ramps to high and back.
// (R9) In manual mode the homing key runs the homing sequence.
// (R10) In manual mode start key runs profiles, stop key halts them.
// (R11) Passing a soft travel limit returns axis to it and raises alarm.
// (R12) After limit alarm clears, only homing or jog may leave the limit.
// (R13) Stop input while moving halts with the configured stop pattern.
// (R14) Stop halt discards pending profiles; next start begins afresh.
// (R15) Stop input polarity selectable normally-open or normally-closed.
// (R16) Four stop patterns: immediate, decelerate, each with or without brake.
// (R17) Emergency halt removes motor power at once; axis coasts.
// (R18) Emergency halt engages the holding brake when one is fitted.
// (R19) Brake-release input disengages the holding brake.
// (R20) Profile pointer returns to first on seek, stop, alarm, preset, release.
// (R21) Alarm-clear input clears error and alarm conditions.
// (R22) Stop during homing aborts it without setting a new reference.
`timescale 1ns/10ps
`default_nettype none

module hsc_homing_stop #(
  parameter logic [15:0] STEP_LOW_CYCLES = 16'(hsc_pkg::STEP_LOW_CYC),
  parameter logic [15:0] STEP_MID_CYCLES = 16'(hsc_pkg::STEP_MID_CYC),
  parameter logic [15:0] STEP_HIGH_CYCLES = 16'(hsc_pkg::STEP_HIGH_CYC),
  parameter logic [15:0] RAMP_CYCLES = 16'(hsc_pkg::RAMP_STEP_CYC)
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire hsc_pkg::hsc_avmm_req_s avmm_req_i,
  output hsc_pkg::hsc_avmm_rsp_s avmm_rsp_o,
  input wire hsc_pkg::hsc_sensor_s sensor_i,
  input wire hsc_pkg::hsc_pendant_s pendant_i,
  input wire hsc_pkg::hsc_host_io_s host_io_i,
  output hsc_pkg::hsc_drive_s drive_o,
  output hsc_pkg::hsc_status_s status_o
);
  import hsc_pkg::*;

  typedef struct packed {
    hsc_state_e state;
    logic [CFG_W-1:0] cfg;
    logic [15:0] home_offset;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [2:0] prof_cnt;
    logic [PROFILE_NUM-1:0][15:0] profile;
    logic [1:0] ptr;
    logic [15:0] pos;
    logic [15:0] target;
    logic [15:0] offset_left;
    logic dir;
    hsc_speed_t level;
    hsc_speed_t goal;
    logic rect;
    logic [15:0] step_cnt;
    logic [15:0] ramp_cnt;
    logic step;
    logic power;
    logic brake;
    logic brake_pend;
    logic alarm;
    logic limit_lock;
    logic home_done;
    logic [5:0] prev_host;
    logic [2:0] prev_key;
    logic ack;
    logic [31:0] rdata;
  } hsc_regs_s;

  hsc_regs_s s_q;
  hsc_regs_s s_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] step_interval(input hsc_speed_t lvl);
    case (lvl)
      SPD_LOW: step_interval = STEP_LOW_CYCLES;
      SPD_MID: step_interval = STEP_MID_CYCLES;
      default: step_interval = STEP_HIGH_CYCLES;
    endcase
  endfunction

  logic stop_act;
  logic [5:0] host_now;
  logic [5:0] host_rise;
  logic [2:0] key_now;
  logic [2:0] key_rise;
  logic manual;
  logic home_req;
  logic start_req;
  logic halt_req;
  logic home_dir;
  logic three;
  logic push;
  logic ref_limit;
  logic far_limit;
  logic jog_key;
  logic above;
  logic below;
  logic [2:0] ptr_next;

  // Stop made active high before edge detection
  assign stop_act = host_io_i.stop ^ s_q.cfg[CFG_STOP_NC_BIT]; // (R15)
  assign host_now = {host_io_i.origin_seek, stop_act, host_io_i.start,
                     host_io_i.alarm_clear_input, host_io_i.preset, host_io_i.brake_release};
  assign host_rise = host_now & ~s_q.prev_host;
  assign key_now = {pendant_i.home_key, pendant_i.start_key, pendant_i.stop_key};
  assign key_rise = key_now & ~s_q.prev_key;
  assign manual = pendant_i.manual_test_screen;
  assign home_req = manual ? key_rise[2] : host_rise[5]; // (R1) (R9)
  assign start_req = manual ? key_rise[1] : host_rise[3]; // (R10)
  assign halt_req = host_rise[4] | (manual & key_rise[0]); // (R10) (R13)
  assign home_dir = s_q.cfg[CFG_HOME_DIR_BIT];
  assign three = s_q.cfg[CFG_THREE_SENSOR_BIT];
  assign push = s_q.cfg[CFG_PUSH_MODE_BIT];
  // Return-side limit sensor and the opposite one
  assign ref_limit = home_dir ? sensor_i.upper_limit_sensor : sensor_i.lower_limit_sensor;
  assign far_limit = home_dir ? sensor_i.lower_limit_sensor : sensor_i.upper_limit_sensor;
  assign jog_key = pendant_i.jog_up | pendant_i.jog_down;
  assign above = $signed(s_q.pos) > $signed(s_q.upper);
  assign below = $signed(s_q.pos) < $signed(s_q.lower);
  assign ptr_next = {1'b0, s_q.ptr} + 3'h1;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.step = 1'b0;
    s_d.prev_host = host_now;
    s_d.prev_key = key_now;

    // Avalon slave: one wait cycle
    s_d.ack = (avmm_req_i.read | avmm_req_i.write) & ~s_q.ack;
    if (avmm_req_i.read && !s_q.ack) begin
      s_d.rdata = 32'h0;
      case (avmm_req_i.address)
        REG_CONFIG: s_d.rdata = {25'h0, s_q.cfg};
        REG_HOME_OFFSET: s_d.rdata = {16'h0, s_q.home_offset};
        REG_UPPER_LIMIT: s_d.rdata = {16'h0, s_q.upper};
        REG_LOWER_LIMIT: s_d.rdata = {16'h0, s_q.lower};
        REG_PROFILE_COUNT: s_d.rdata = {29'h0, s_q.prof_cnt};
        REG_STATUS: s_d.rdata = {21'h0, s_q.ptr, s_q.state, s_q.power, s_q.brake,
                                 s_q.limit_lock, s_q.home_done, s_q.alarm};
        REG_POSITION: s_d.rdata = {{16{s_q.pos[15]}}, s_q.pos};
        default: begin
          if (avmm_req_i.address[7:4] == REG_PROFILE_PAGE && avmm_req_i.address[1:0] == 2'h0) begin
            s_d.rdata = {16'h0, s_q.profile[avmm_req_i.address[3:2]]};
          end
        end
      endcase
    end
    if (avmm_req_i.write && s_q.ack) begin
      case (avmm_req_i.address)
        REG_CONFIG: s_d.cfg = avmm_req_i.writedata[CFG_W-1:0];
        REG_HOME_OFFSET: s_d.home_offset = avmm_req_i.writedata[15:0];
        REG_UPPER_LIMIT: s_d.upper = avmm_req_i.writedata[15:0];
        REG_LOWER_LIMIT: s_d.lower = avmm_req_i.writedata[15:0];
        REG_PROFILE_COUNT: begin
          s_d.prof_cnt = (avmm_req_i.writedata[31:0] > 32'(PROFILE_COUNT_MAX)) ?
                         PROFILE_COUNT_MAX : avmm_req_i.writedata[2:0];
          s_d.ptr = 2'h0;
        end
        default: begin
          if (avmm_req_i.address[7:4] == REG_PROFILE_PAGE && avmm_req_i.address[1:0] == 2'h0) begin
            s_d.profile[avmm_req_i.address[3:2]] = avmm_req_i.writedata[15:0];
          end
        end
      endcase
    end

    // Step engine
    if (s_q.level != SPD_STOP) begin
      if (s_q.step_cnt >= step_interval(s_q.level) - 16'h1) begin
        s_d.step = 1'b1;
        s_d.step_cnt = 16'h0;
        s_d.pos = s_q.dir ? s_q.pos + 16'h1 : s_q.pos - 16'h1;
      end else begin
        s_d.step_cnt = s_q.step_cnt + 16'h1;
      end
    end else begin
      s_d.step_cnt = 16'h0;
    end

    // Speed ramp; rectangular moves jump to goal
    if (s_q.rect) begin
      s_d.level = s_q.goal; // (R6)
      s_d.ramp_cnt = 16'h0;
    end else if (s_q.level == s_q.goal) begin
      s_d.ramp_cnt = 16'h0;
    end else if (s_q.ramp_cnt >= RAMP_CYCLES - 16'h1) begin
      s_d.ramp_cnt = 16'h0;
      s_d.level = (s_q.level < s_q.goal) ? s_q.level + 2'h1 : s_q.level - 2'h1; // (R8)
    end else begin
      s_d.ramp_cnt = s_q.ramp_cnt + 16'h1;
    end

    case (s_q.state)
      ST_IDLE: begin
        s_d.level = SPD_STOP;
        s_d.goal = SPD_STOP;
        if (home_req && !s_q.alarm) begin
          s_d.brake = 1'b0;
          s_d.limit_lock = 1'b0; // (R12)
          s_d.home_done = 1'b0;
          s_d.ptr = 2'h0; // (R20)
          s_d.rect = ~three | push; // (R6)
          s_d.goal = (~three | push) ? SPD_LOW : SPD_HIGH; // (R4)
          if (three && sensor_i.origin_sensor) begin
            s_d.state = ST_HOME_ESC; // (R5)
            s_d.dir = ~home_dir;
          end else if (ref_limit) begin
            s_d.state = three ? ST_HOME_REV : ST_HOME_OFFSET; // (R5)
            s_d.dir = ~home_dir;
            s_d.offset_left = s_q.home_offset;
          end else begin
            s_d.state = ST_HOME_SEEK; // (R1)
            s_d.dir = home_dir;
          end
        end else if (manual && jog_key && !s_q.alarm) begin
          s_d.state = ST_JOG; // (R8)
          s_d.dir = pendant_i.jog_up;
          s_d.limit_lock = 1'b0; // (R12)
          s_d.brake = 1'b0;
          s_d.rect = 1'b0;
          s_d.goal = SPD_LOW;
          s_d.level = SPD_LOW;
        end else if (start_req && !s_q.alarm && !s_q.limit_lock && s_q.prof_cnt != 3'h0) begin
          s_d.target = s_q.profile[s_q.ptr]; // (R10)
          s_d.ptr = (ptr_next >= s_q.prof_cnt) ? 2'h0 : ptr_next[1:0];
          s_d.brake = 1'b0;
          s_d.rect = push;
          s_d.goal = push ? SPD_LOW : SPD_HIGH;
          s_d.dir = $signed(s_q.profile[s_q.ptr]) > $signed(s_q.pos);
          if (s_q.profile[s_q.ptr] != s_q.pos) begin
            s_d.state = ST_POSITION;
          end
        end
      end
      ST_JOG: begin
        if (!manual || !jog_key) begin
          s_d.state = ST_DECEL; // (R8)
          s_d.brake_pend = 1'b0;
        end else if (s_q.dir ? sensor_i.upper_limit_sensor : sensor_i.lower_limit_sensor) begin
          s_d.state = ST_IDLE;
        end else begin
          s_d.goal = pendant_i.shift ? SPD_HIGH : SPD_LOW; // (R8)
        end
      end
      ST_HOME_ESC: begin
        if (!sensor_i.origin_sensor) begin
          s_d.state = ST_HOME_SEEK; // (R5)
          s_d.dir = home_dir;
        end
      end
      ST_HOME_SEEK: begin
        if (three ? sensor_i.origin_sensor : ref_limit) begin
          s_d.state = ST_HOME_OFFSET; // (R4)
          s_d.dir = ~home_dir;
          s_d.offset_left = s_q.home_offset;
        end else if (three && ref_limit) begin
          s_d.state = ST_HOME_REV; // (R5)
          s_d.dir = ~home_dir;
        end
      end
      ST_HOME_REV: begin
        if (sensor_i.origin_sensor) begin
          s_d.state = ST_HOME_OFFSET;
          s_d.offset_left = s_q.home_offset;
        end else if (far_limit) begin
          s_d.state = ST_IDLE;
          s_d.alarm = 1'b1;
          s_d.ptr = 2'h0; // (R20)
        end
      end
      ST_HOME_OFFSET: begin
        s_d.rect = 1'b1;
        s_d.goal = SPD_LOW;
        if (s_q.offset_left == 16'h0) begin
          s_d.pos = 16'h0; // (R2) (R3)
          s_d.home_done = 1'b1;
          s_d.level = SPD_STOP;
          s_d.goal = SPD_STOP;
          s_d.state = ST_IDLE;
        end else if (s_d.step) begin
          s_d.offset_left = s_q.offset_left - 16'h1; // (R2)
        end
      end
      ST_POSITION: begin
        if (above || below) begin
          s_d.alarm = 1'b1; // (R11)
          s_d.limit_lock = 1'b1; // (R12)
          s_d.ptr = 2'h0; // (R20)
          s_d.state = ST_LIMIT_RETURN;
          s_d.dir = below;
          s_d.rect = 1'b1;
          s_d.goal = SPD_LOW;
        end else if (s_q.pos == s_q.target) begin
          s_d.level = SPD_STOP;
          s_d.goal = SPD_STOP;
          s_d.state = ST_IDLE;
        end
      end
      ST_LIMIT_RETURN: begin
        if (!above && !below) begin
          s_d.level = SPD_STOP; // (R11)
          s_d.goal = SPD_STOP;
          s_d.state = ST_IDLE;
        end
      end
      ST_DECEL: begin
        s_d.goal = SPD_STOP;
        if (s_q.level == SPD_STOP) begin
          s_d.brake = s_q.brake_pend; // (R16)
          s_d.state = ST_IDLE;
        end
      end
      default: s_d.state = ST_IDLE;
    endcase
    if (s_d.dir != s_q.dir) begin
      s_d.step = 1'b0;
      s_d.pos = s_q.pos;
    end

    // Stop pattern halt; drops pending profiles
    if (halt_req) begin
      s_d.ptr = 2'h0; // (R14) (R20)
      if (s_q.state != ST_IDLE && s_q.state != ST_DECEL) begin
        s_d.goal = SPD_STOP; // (R13) (R22)
        s_d.rect = 1'b0;
        if (s_q.cfg[CFG_STOP_DECEL_BIT]) begin
          s_d.state = ST_DECEL; // (R16)
          s_d.brake_pend = s_q.cfg[CFG_STOP_BRAKE_BIT];
        end else begin
          s_d.state = ST_IDLE; // (R16)
          s_d.level = SPD_STOP;
          s_d.brake = s_q.cfg[CFG_STOP_BRAKE_BIT];
        end
      end
    end

    if (host_rise[1]) begin
      s_d.ptr = 2'h0; // (R20)
      if (s_q.state == ST_IDLE) begin
        s_d.pos = 16'h0;
      end
    end
    if (host_rise[0]) begin
      s_d.brake = 1'b0; // (R19)
      s_d.ptr = 2'h0; // (R20)
    end
    // New alarm wins over clear
    if (host_rise[2] && !(s_d.alarm && !s_q.alarm)) begin
      s_d.alarm = 1'b0; // (R21)
    end

    // Emergency halt overrides all
    s_d.power = ~pendant_i.emergency_halt; // (R17)
    if (pendant_i.emergency_halt) begin
      s_d.state = ST_IDLE; // (R17)
      s_d.step = 1'b0;
      s_d.pos = s_q.pos;
      s_d.level = SPD_STOP;
      s_d.goal = SPD_STOP;
      s_d.ptr = 2'h0; // (R20)
      if (s_q.cfg[CFG_BRAKE_FITTED_BIT]) begin
        s_d.brake = 1'b1; // (R18)
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.cfg <= CONFIG_RESET;
      s_q.home_offset <= HOME_OFFSET_RESET;
      s_q.upper <= UPPER_LIMIT_RESET;
      s_q.lower <= LOWER_LIMIT_RESET;
      s_q.prof_cnt <= PROFILE_COUNT_RESET;
      s_q.power <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avmm_rsp_o.readdata = s_q.rdata;
  assign avmm_rsp_o.waitrequest = (avmm_req_i.read | avmm_req_i.write) & ~s_q.ack;
  assign drive_o.motor_enable = s_q.power;
  assign drive_o.step = s_q.step;
  assign drive_o.dir = s_q.dir;
  assign drive_o.speed = s_q.level;
  assign drive_o.brake_engage = s_q.brake;
  assign status_o.alarm = s_q.alarm;
  assign status_o.home_done = s_q.home_done;
  assign status_o.busy = s_q.state != ST_IDLE;

endmodule

`default_nettype wire

//--- hdl/hsc_pkg.sv
// Homing and stop control package
package hsc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int STEP_LOW_NS = 400000;
  localparam int STEP_MID_NS = 200000;
  localparam int STEP_HIGH_NS = 100000;
  localparam int RAMP_STEP_NS = 1000000;
  localparam int STEP_LOW_CYC = STEP_LOW_NS / CLK_PERIOD_NS;
  localparam int STEP_MID_CYC = STEP_MID_NS / CLK_PERIOD_NS;
  localparam int STEP_HIGH_CYC = STEP_HIGH_NS / CLK_PERIOD_NS;
  localparam int RAMP_STEP_CYC = RAMP_STEP_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_HOME_OFFSET = 8'h04;
  localparam logic [7:0] REG_UPPER_LIMIT = 8'h08;
  localparam logic [7:0] REG_LOWER_LIMIT = 8'h0c;
  localparam logic [7:0] REG_PROFILE_COUNT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_POSITION = 8'h18;
  localparam logic [3:0] REG_PROFILE_PAGE = 4'h2;
  localparam int PROFILE_NUM = 4;

  // ----------------------------------------------------------------
  // Config fields and reset values
  // ----------------------------------------------------------------
  localparam int CFG_HOME_DIR_BIT = 0;
  localparam int CFG_THREE_SENSOR_BIT = 1;
  localparam int CFG_PUSH_MODE_BIT = 2;
  localparam int CFG_STOP_NC_BIT = 3;
  localparam int CFG_STOP_DECEL_BIT = 4;
  localparam int CFG_STOP_BRAKE_BIT = 5;
  localparam int CFG_BRAKE_FITTED_BIT = 6;
  localparam int CFG_W = 7;
  localparam logic [CFG_W-1:0] CONFIG_RESET = 7'h40;
  localparam logic [15:0] HOME_OFFSET_RESET = 16'h0010;
  localparam logic [15:0] UPPER_LIMIT_RESET = 16'h7000;
  localparam logic [15:0] LOWER_LIMIT_RESET = 16'h9000;
  localparam logic [2:0] PROFILE_COUNT_RESET = 3'h0;
  localparam logic [2:0] PROFILE_COUNT_MAX = 3'h4;

  // ----------------------------------------------------------------
  // Speed levels
  // ----------------------------------------------------------------
  typedef logic [1:0] hsc_speed_t;
  localparam hsc_speed_t SPD_STOP = 2'h0;
  localparam hsc_speed_t SPD_LOW = 2'h1;
  localparam hsc_speed_t SPD_MID = 2'h2;
  localparam hsc_speed_t SPD_HIGH = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_JOG,
    ST_HOME_ESC,
    ST_HOME_SEEK,
    ST_HOME_REV,
    ST_HOME_OFFSET,
    ST_POSITION,
    ST_LIMIT_RETURN,
    ST_DECEL
  } hsc_state_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } hsc_avmm_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } hsc_avmm_rsp_s;

  typedef struct packed {
    logic origin_sensor;
    logic lower_limit_sensor;
    logic upper_limit_sensor;
  } hsc_sensor_s;

  typedef struct packed {
    logic manual_test_screen;
    logic jog_up;
    logic jog_down;
    logic shift;
    logic home_key;
    logic start_key;
    logic stop_key;
    logic emergency_halt;
  } hsc_pendant_s;

  typedef struct packed {
    logic origin_seek;
    logic stop;
    logic start;
    logic alarm_clear_input;
    logic preset;
    logic brake_release;
  } hsc_host_io_s;

  typedef struct packed {
    logic motor_enable;
    logic step;
    logic dir;
    hsc_speed_t speed;
    logic brake_engage;
  } hsc_drive_s;

  typedef struct packed {
    logic alarm;
    logic home_done;
    logic busy;
  } hsc_status_s;

endpackage

//--- dv/hsc_axis_model.sv
// Axis model: counts steps, drives the sensors
`timescale 1ns/10ps
`default_nettype none
module hsc_axis_model
  import hsc_pkg::*;
#(
  parameter int LIM = 60,
  parameter int ORG = 20
) (
  input wire logic core_clk_i,
  input wire hsc_pkg::hsc_drive_s drive_i,
  output hsc_pkg::hsc_sensor_s sensor_o,
  output var int pos_o
);
  // Position survives reset
  initial pos_o = 0;
  always @(posedge core_clk_i) begin
    if (drive_i.step) begin
      pos_o <= drive_i.dir ? pos_o + 1 : pos_o - 1;
    end
  end
  assign sensor_o.lower_limit_sensor = pos_o <= -LIM;
  assign sensor_o.upper_limit_sensor = pos_o >= LIM;
  assign sensor_o.origin_sensor = pos_o >= ORG && pos_o < ORG + 5;
endmodule
`default_nettype wire

//--- dv/hsc_homing_stop_chk.sv
// Port checker for the sequencer
`timescale 1ns/10ps
`default_nettype none
module hsc_homing_stop_chk
  import hsc_pkg::*;
#(
  parameter logic [15:0] RAMP_CYCLES = 16'(RAMP_STEP_CYC)
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire hsc_pkg::hsc_avmm_req_s avmm_req_i,
  input wire hsc_pkg::hsc_avmm_rsp_s avmm_rsp_o,
  input wire hsc_pkg::hsc_sensor_s sensor_i,
  input wire hsc_pkg::hsc_pendant_s pendant_i,
  input wire hsc_pkg::hsc_host_io_s host_io_i,
  input wire hsc_pkg::hsc_drive_s drive_o,
  input wire hsc_pkg::hsc_status_s status_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  logic stop_prev_q;
  logic [19:0] stop_cyc_q;
  logic [19:0] stop_cyc_d;
  // Cycles from a stop edge until idle
  always_comb begin
    stop_cyc_d = 20'h0;
    if (status_o.busy && (stop_cyc_q != 20'h0 || (host_io_i.stop && !stop_prev_q))) begin
      stop_cyc_d = stop_cyc_q + 20'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    stop_prev_q <= host_io_i.stop;
    stop_cyc_q <= rst_i ? 20'h0 : stop_cyc_d;
  end
  sequence s_bus_wait;
    (avmm_req_i.read || avmm_req_i.write) && avmm_rsp_o.waitrequest;
  endsequence
  sequence s_jog_up_req;
    pendant_i.manual_test_screen && pendant_i.jog_up && !pendant_i.jog_down
      && !pendant_i.home_key && !pendant_i.emergency_halt && !host_io_i.stop
      && !sensor_i.upper_limit_sensor && !status_o.busy && !status_o.alarm;
  endsequence
  sequence s_seek_req;
    $rose(host_io_i.origin_seek) && !pendant_i.manual_test_screen && !status_o.busy
      && !status_o.alarm && !pendant_i.emergency_halt;
  endsequence
  a_bus_one_wait: assert property (s_bus_wait |=> !avmm_rsp_o.waitrequest)
    else $error("long wait");
  a_emg_power_cut: assert property (
    pendant_i.emergency_halt |=> !drive_o.motor_enable)
    else $error("power on in halt");
  a_emg_coast_idle: assert property (
    pendant_i.emergency_halt |=> !status_o.busy && drive_o.speed == SPD_STOP)
    else $error("moving in halt");
  a_step_needs_power: assert property (
    drive_o.step |-> drive_o.motor_enable ##1 !drive_o.step)
    else $error("bad step pulse");
  a_jog_low_start: assert property (
    s_jog_up_req |=> status_o.busy && drive_o.speed == SPD_LOW && drive_o.dir)
    else $error("jog start wrong");
  a_seek_begins: assert property (
    s_seek_req |=> status_o.busy && !status_o.home_done)
    else $error("no homing");
  a_brake_frees: assert property (
    $rose(host_io_i.brake_release) && !pendant_i.emergency_halt |=> !drive_o.brake_engage)
    else $error("brake held");
  a_alarm_clears: assert property (
    $rose(host_io_i.alarm_clear_input) && !status_o.busy |=> !status_o.alarm)
    else $error("alarm not cleared");
  a_stop_bounded: assert property (
    stop_cyc_q <= 20'(4 * RAMP_CYCLES + 16))
    else $error("stop too slow");
endmodule
bind hsc_homing_stop hsc_homing_stop_chk #(.RAMP_CYCLES(RAMP_CYCLES)) u_hsc_homing_stop_chk (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .avmm_req_i(avmm_req_i),
  .avmm_rsp_o(avmm_rsp_o),
  .sensor_i(sensor_i),
  .pendant_i(pendant_i),
  .host_io_i(host_io_i),
  .drive_o(drive_o),
  .status_o(status_o)
);
`default_nettype wire

//--- dv/hsc_homing_stop_tb.sv
// Self-checking bench for the homing and stop sequencer
`timescale 1ns/10ps
`default_nettype none
module hsc_homing_stop_tb;
  import hsc_pkg::*;
  localparam int LIM = 60;
  localparam int ORG = 20;
  logic clk = 0;
  logic rst = 1;
  hsc_avmm_req_s rq = '0;
  hsc_avmm_rsp_s rs;
  hsc_sensor_s sn;
  hsc_pendant_s pd = '0;
  hsc_host_io_s hi = '0;
  hsc_drive_s dv;
  hsc_status_s st;
  int pos;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] t;
  logic [7:0] ra[8] = '{REG_CONFIG, REG_HOME_OFFSET, REG_UPPER_LIMIT, REG_LOWER_LIMIT,
    REG_PROFILE_COUNT, REG_POSITION, REG_STATUS, 8'h3c};
  logic [31:0] rv[8] = '{32'(CONFIG_RESET), 32'(HOME_OFFSET_RESET), 32'(UPPER_LIMIT_RESET),
    32'(LOWER_LIMIT_RESET), 32'h0, 32'h0, 32'h10, 32'h0};
  always #12.5 clk = ~clk;
  hsc_homing_stop #(.STEP_LOW_CYCLES(16'h0008), .STEP_MID_CYCLES(16'h0004),
    .STEP_HIGH_CYCLES(16'h0002), .RAMP_CYCLES(16'h0006)) u_hsc_homing_stop (
    .core_clk_i(clk), .rst_i(rst), .avmm_req_i(rq), .avmm_rsp_o(rs), .sensor_i(sn),
    .pendant_i(pd), .host_io_i(hi), .drive_o(dv), .status_o(st));
  hsc_axis_model #(.LIM(LIM), .ORG(ORG)) u_hsc_axis_model (
    .core_clk_i(clk), .drive_i(dv), .sensor_o(sn), .pos_o(pos));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rq <= '{read: !w, write: w, address: a, writedata: d};
    do @(posedge clk); while (rs.waitrequest !== 1'b0);
    rq <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic spd(input hsc_speed_t e);
    @(negedge clk);
    chk("speed", 32'(e), 32'(dv.speed));
    @(posedge clk);
  endtask
  task automatic idle_wait;
    tick(2);
    while (st.busy !== 1'b0) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Read results compared as they appear
  always @(posedge clk) begin
    if (rq.read && rs.waitrequest === 1'b0) begin
      chk("readdata", exp_q.pop_front(), rs.readdata & msk_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(32'h16a7));
    tick(6);
    rst <= 0;
    bus(1'b1, REG_STATUS, 32'h0);
    bus(1'b1, 8'h3c, 32'hffff_ffff);
    foreach (ra[i]) rd(ra[i], rv[i], 32'hffff_ffff);
    $display("test reset done");
    bus(1'b1, REG_HOME_OFFSET, 32'h5);
    bus(1'b1, REG_UPPER_LIMIT, 32'd30);
    bus(1'b1, REG_LOWER_LIMIT, 32'hffff_ffe2);
    bus(1'b1, REG_CONFIG, 32'h40);
    hi.origin_seek <= 1;
    tick(24);
    spd(SPD_LOW);
    idle_wait;
    chk("axis", 32'(5 - LIM), 32'(pos));
    rd(REG_POSITION, 32'h0, 32'hffff_ffff);
    rd(REG_STATUS, 32'h2, 32'h1e3);
    hi.origin_seek <= 0;
    bus(1'b1, REG_CONFIG, 32'h43);
    pd.manual_test_screen <= 1;
    pd.home_key <= 1;
    tick(24);
    spd(SPD_HIGH);
    rd(REG_STATUS, 32'h60, 32'h1e0);
    idle_wait;
    chk("axis", 32'(ORG - 5), 32'(pos));
    pd.home_key <= 0;
    $display("test homing done");
    bus(1'b1, REG_CONFIG, 32'h40);
    pd.manual_test_screen <= 0;
    hi.origin_seek <= 1;
    tick(40);
    hi.stop <= 1;
    idle_wait;
    hi.stop <= 0;
    hi.origin_seek <= 0;
    rd(REG_STATUS, 32'h0, 32'h602);
    rd(REG_POSITION, 32'(pos - 15), 32'hffff_ffff);
    $display("test abort done");
    pd.manual_test_screen <= 1;
    pd.jog_up <= 1;
    tick(3);
    spd(SPD_LOW);
    pd.shift <= 1;
    tick(30);
    spd(SPD_HIGH);
    pd.shift <= 0;
    tick(30);
    spd(SPD_LOW);
    pd.emergency_halt <= 1;
    tick(3);
    rd(REG_STATUS, 32'h8, 32'h1f8);
    pd.emergency_halt <= 0;
    pd.jog_up <= 0;
    tick(2);
    hi.brake_release <= 1;
    tick(2);
    rd(REG_STATUS, 32'h0, 32'h608);
    hi.brake_release <= 0;
    $display("test jog and emergency done");
    t = 32'($urandom_range(20, 1));
    bus(1'b1, REG_PROFILE_COUNT, 32'h2);
    bus(1'b1, {REG_PROFILE_PAGE, 4'h0}, t);
    bus(1'b1, {REG_PROFILE_PAGE, 4'h4}, 32'd40);
    pd.start_key <= 1;
    idle_wait;
    pd.start_key <= 0;
    rd(REG_POSITION, t, 32'hffff_ffff);
    rd(REG_STATUS, 32'h200, 32'h607);
    pd.start_key <= 1;
    idle_wait;
    pd.start_key <= 0;
    rd(REG_STATUS, 32'h5, 32'h607);
    hi.alarm_clear_input <= 1;
    tick(2);
    rd(REG_STATUS, 32'h4, 32'h607);
    hi.alarm_clear_input <= 0;
    pd.start_key <= 1;
    tick(3);
    rd(REG_STATUS, 32'h4, 32'h1e7);
    pd.start_key <= 0;
    pd.jog_down <= 1;
    tick(20);
    pd.jog_down <= 0;
    tick(3);
    rd(REG_STATUS, 32'h0, 32'h4);
    $display("test soft limit done");
    bus(1'b1, {REG_PROFILE_PAGE, 4'h0}, 32'hffff_ffe4);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, REG_CONFIG, 32'(32'h40 | (p << 4)));
      pd.start_key <= 1;
      tick(12);
      hi.stop <= 1;
      idle_wait;
      hi.stop <= 0;
      pd.start_key <= 0;
      rd(REG_STATUS, 32'((p >> 1) << 3), 32'h7e9);
      hi.brake_release <= 1;
      tick(2);
      hi.brake_release <= 0;
    end
    bus(1'b1, REG_CONFIG, 32'h48);
    hi.stop <= 1;
    pd.start_key <= 1;
    tick(12);
    hi.stop <= 0;
    tick(4);
    rd(REG_STATUS, 32'h0, 32'h1e0);
    pd.start_key <= 0;
    $display("test stop patterns done");
    finish_test;
  end
endmodule
`default_nettype wire
